// ===== rx_paging_pkg.sv
// Constants for the receive-port register paging block.
// Summary of operation
// - Accesses to offsets 0x4D-0x7F and 0xD0-0xDF go through port paging.
// - Select bits 5:4 choose which port copy supplies paged read data.
// - Select bits 3:0 enable writes to ports 3:0; several may be set.
// - A cleared write enable blocks paged writes to that port.
// - Every access source keeps its own independent paging selection.
// - Select bits 7:6 read zero for local host sources.
// - Select bits 7:6 read the carrying port index for control-channel sources.
// - Read port resets to 0 locally, to the carrying port for control channel.
// - Write enable resets to one only for the control channel's own port.
// - Status register at 0x4D returns status of the selected read port.
// - Status bits 7:6 report the selected read port number.
// - Status bit 5 latches a control-channel checksum fault until status is read.
package rx_paging_pkg;
  localparam int NUM_PORTS = 4;
  localparam int NUM_LOCAL = 2;
  localparam int NUM_SOURCES = 6;
  localparam logic [2:0] FIRST_CTRL_SOURCE = 3'h2;
  localparam logic [2:0] NUM_SOURCES_CODE = 3'h6;
  localparam logic [7:0] ADDR_PAGE_SELECT = 8'h4c;
  localparam logic [7:0] ADDR_LANE_STATUS_FIRST = 8'h4d;
  localparam logic [7:0] PAGED_LOW_START = 8'h4d;
  localparam logic [7:0] PAGED_LOW_END = 8'h7f;
  localparam logic [7:0] PAGED_HIGH_START = 8'hd0;
  localparam logic [7:0] PAGED_HIGH_END = 8'hdf;
  localparam int PHYS_MSB = 7;
  localparam int PHYS_LSB = 6;
  localparam int READ_MSB = 5;
  localparam int READ_LSB = 4;
  localparam int WRITE_MSB = 3;
  localparam int WRITE_LSB = 0;
  localparam int STS_PORT_MSB = 7;
  localparam int STS_PORT_LSB = 6;
  localparam int STS_CHECKSUM_BIT = 5;
  localparam logic [1:0] LOCAL_READ_RESET = 2'h0;
  localparam logic [3:0] LOCAL_WRITE_RESET = 4'h0;
  localparam logic [3:0] CTRL_WRITE_RESET_BASE = 4'h1;
endpackage : rx_paging_pkg

// ===== rx_port_register_paging.sv
// Per-source port paging of the receive-port register space.
`timescale 1ns/1ps
module rx_port_register_paging (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [2:0] req_source,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [7:0] shared_rd_data,
  input wire logic [3:0][7:0] port_rd_data,
  input wire logic [3:0] crc_error_event,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic shared_wr_strobe,
  output logic [3:0] port_wr_strobe,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  logic [1:0] read_sel_reg [rx_paging_pkg::NUM_SOURCES];
  logic [1:0] read_sel_next [rx_paging_pkg::NUM_SOURCES];
  logic [3:0] write_en_reg [rx_paging_pkg::NUM_SOURCES];
  logic [3:0] write_en_next [rx_paging_pkg::NUM_SOURCES];
  logic [3:0] checksum_fault_reg;
  logic [3:0] checksum_fault_next;
  logic rsp_valid_next;
  logic [7:0] rsp_rdata_next;
  logic shared_wr_strobe_next;
  logic [3:0] port_wr_strobe_next;
  logic [7:0] wr_addr_next;
  logic [7:0] wr_data_next;
  logic src_ok;
  logic [2:0] src_idx;
  logic is_ctrl;
  logic [1:0] phys_port;
  logic [1:0] cur_read;
  logic [3:0] cur_write;
  logic in_paged;
  logic sel_hit;
  logic sts_hit;
  logic [7:0] status_value;

  always_comb begin
    src_ok = req_valid && (req_source < rx_paging_pkg::NUM_SOURCES_CODE);
    src_idx = src_ok ? req_source : 3'h0;
    is_ctrl = src_idx >= rx_paging_pkg::FIRST_CTRL_SOURCE;
    phys_port = is_ctrl ? 2'(src_idx - rx_paging_pkg::FIRST_CTRL_SOURCE) : 2'h0;
    cur_read = read_sel_reg[src_idx];
    cur_write = write_en_reg[src_idx];
    sel_hit = req_addr == rx_paging_pkg::ADDR_PAGE_SELECT;
    sts_hit = req_addr == rx_paging_pkg::ADDR_LANE_STATUS_FIRST;
    in_paged = ((req_addr >= rx_paging_pkg::PAGED_LOW_START) &&
                (req_addr <= rx_paging_pkg::PAGED_LOW_END)) ||
               ((req_addr >= rx_paging_pkg::PAGED_HIGH_START) &&
                (req_addr <= rx_paging_pkg::PAGED_HIGH_END));
    status_value = 8'h00;
    status_value[rx_paging_pkg::STS_PORT_MSB:rx_paging_pkg::STS_PORT_LSB] = cur_read;
    status_value[rx_paging_pkg::STS_CHECKSUM_BIT] = checksum_fault_reg[cur_read];
  end

  // Selection state, one copy per source.
  generate
    for (genvar s = 0; s < rx_paging_pkg::NUM_SOURCES; s++) begin : g_source
      localparam logic [1:0] READ_RESET = (s < rx_paging_pkg::NUM_LOCAL) ?
        rx_paging_pkg::LOCAL_READ_RESET : 2'(s - rx_paging_pkg::NUM_LOCAL);
      localparam logic [3:0] WRITE_RESET = (s < rx_paging_pkg::NUM_LOCAL) ?
        rx_paging_pkg::LOCAL_WRITE_RESET :
        4'(rx_paging_pkg::CTRL_WRITE_RESET_BASE << (s - rx_paging_pkg::NUM_LOCAL));

      always_comb begin
        read_sel_next[s] = read_sel_reg[s];
        write_en_next[s] = write_en_reg[s];
        if (src_ok && req_write && sel_hit && (src_idx == 3'(s))) begin
          read_sel_next[s] = req_wdata[rx_paging_pkg::READ_MSB:rx_paging_pkg::READ_LSB];
          write_en_next[s] = req_wdata[rx_paging_pkg::WRITE_MSB:rx_paging_pkg::WRITE_LSB];
        end
      end

      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          read_sel_reg[s] <= READ_RESET;
          write_en_reg[s] <= WRITE_RESET;
        end else begin
          read_sel_reg[s] <= read_sel_next[s];
          write_en_reg[s] <= write_en_next[s];
        end
      end
    end
  endgenerate

  // Sticky checksum faults; a new fault wins over the clearing read.
  always_comb begin
    checksum_fault_next = checksum_fault_reg;
    if (src_ok && !req_write && sts_hit) begin
      checksum_fault_next[cur_read] = 1'b0;
    end
    checksum_fault_next = checksum_fault_next | crc_error_event;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      checksum_fault_reg <= 4'h0;
    end else begin
      checksum_fault_reg <= checksum_fault_next;
    end
  end

  // Request decode, read mux and write strobes.
  always_comb begin
    rsp_valid_next = src_ok;
    rsp_rdata_next = 8'h00;
    shared_wr_strobe_next = 1'b0;
    port_wr_strobe_next = 4'h0;
    wr_addr_next = wr_addr;
    wr_data_next = wr_data;
    if (src_ok) begin
      if (req_write) begin
        wr_addr_next = req_addr;
        wr_data_next = req_wdata;
        if (sel_hit || sts_hit) begin
          port_wr_strobe_next = 4'h0;
        end else if (in_paged) begin
          port_wr_strobe_next = cur_write;
        end else begin
          shared_wr_strobe_next = 1'b1;
        end
      end else begin
        if (sel_hit) begin
          rsp_rdata_next[rx_paging_pkg::PHYS_MSB:rx_paging_pkg::PHYS_LSB] = phys_port;
          rsp_rdata_next[rx_paging_pkg::READ_MSB:rx_paging_pkg::READ_LSB] = cur_read;
          rsp_rdata_next[rx_paging_pkg::WRITE_MSB:rx_paging_pkg::WRITE_LSB] = cur_write;
        end else if (sts_hit) begin
          rsp_rdata_next = status_value;
        end else if (in_paged) begin
          rsp_rdata_next = port_rd_data[cur_read];
        end else begin
          rsp_rdata_next = shared_rd_data;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      shared_wr_strobe <= 1'b0;
      port_wr_strobe <= 4'h0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      rsp_valid <= rsp_valid_next;
      rsp_rdata <= rsp_rdata_next;
      shared_wr_strobe <= shared_wr_strobe_next;
      port_wr_strobe <= port_wr_strobe_next;
      wr_addr <= wr_addr_next;
      wr_data <= wr_data_next;
    end
  end
endmodule : rx_port_register_paging

// ===== rx_port_register_paging_assertions.sv
// Port-level checks for the paging block.
`timescale 1ns/1ps
module rx_port_register_paging_assertions (
  input wire logic clock, sys_rst, req_valid, req_write, rsp_valid, shared_wr_strobe,
  input wire logic [2:0] req_source,
  input wire logic [7:0] req_addr, req_wdata, shared_rd_data, rsp_rdata, wr_addr, wr_data,
  input wire logic [3:0] port_wr_strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire tk = req_valid && req_source < 3'h6;
  wire pg = (req_addr > 8'h4d && req_addr < 8'h80) || req_addr[7:4] == 4'hd;
  wire sh = !pg && req_addr[7:1] != 7'h26;
  sequence sel_rd; tk && !req_write && req_addr == 8'h4c; endsequence
  a_shared_read: assert property (tk && !req_write && sh
    |=> rsp_rdata == $past(shared_rd_data)) else $error("Bad shared read.");
  a_shared_write: assert property (tk && req_write && sh
    |=> shared_wr_strobe && !port_wr_strobe) else $error("Bad shared write.");
  a_paged_write: assert property (tk && req_write && pg
    |=> !shared_wr_strobe && wr_addr == $past(req_addr)) else $error("Bad paged write.");
  a_strobe_data: assert property (|port_wr_strobe
    |-> wr_data == $past(req_wdata)) else $error("Bad write data.");
  a_phys_local: assert property (sel_rd ##0 req_source < 3'h2
    |=> rsp_rdata[7:6] == 2'h0) else $error("Bad local port field.");
  a_phys_ctrl: assert property (sel_rd ##0 req_source > 3'h1
    |=> rsp_rdata[7:6] == 2'($past(req_source) - 3'h2)) else $error("Bad channel field.");
  a_status_ro: assert property (tk && req_write && req_addr == 8'h4d
    |=> !port_wr_strobe && !shared_wr_strobe) else $error("Status write acted.");
  a_read_no_strobe: assert property (tk && !req_write
    |=> !port_wr_strobe && !shared_wr_strobe) else $error("Read caused a write.");
  a_idle_quiet: assert property (!tk
    |=> !rsp_valid && !port_wr_strobe) else $error("Output without request.");
endmodule : rx_port_register_paging_assertions
bind rx_port_register_paging rx_port_register_paging_assertions u_chk (.*);

// ===== rx_port_copies_model.sv
// Register copies that sit behind the paging block.
`timescale 1ns/1ps
module rx_port_copies_model (
  input wire logic clock,
  input wire logic [3:0] port_wr_strobe,
  input wire logic [7:0] req_addr, wr_addr, wr_data,
  output logic [7:0] shared_rd_data,
  output logic [3:0][7:0] port_rd_data
);
  logic [7:0] mem [1024];
  initial for (int i = 0; i < 1024; i++) mem[i] = 8'(i ^ (i >> 4));
  always @(posedge clock)
    for (int p = 0; p < 4; p++) if (port_wr_strobe[p]) mem[{2'(p), wr_addr}] <= wr_data;
  assign shared_rd_data = ~req_addr;
  always_comb for (int p = 0; p < 4; p++) port_rd_data[p] = mem[{2'(p), req_addr}];
endmodule : rx_port_copies_model

// ===== tb_rx_port_register_paging.sv
// Self-checking bench for the paging block.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t %h %h", $time, g, e); end end
module tb_rx_port_register_paging;
  logic clock = 0, sys_rst = 1, req_valid = 0, req_write = 0, rsp_valid, shared_wr_strobe;
  logic [2:0] req_source = 0;
  logic [7:0] req_addr = 0, req_wdata = 0, shared_rd_data, rsp_rdata, wr_addr, wr_data, x;
  logic [3:0][7:0] port_rd_data;
  logic [3:0] crc_error_event = 0, port_wr_strobe, fl = 0;
  logic [7:0] q[$], em[1024], al[7] = '{8'h4e, 8'h7f, 8'hd0, 8'hdf, 8'h4b, 8'h80, 8'he0};
  logic [1:0] rp[6] = '{0, 0, 0, 1, 2, 3};
  logic [3:0] we[6] = '{0, 0, 1, 2, 4, 8};
  int err_total = 0, tests_run = 0;
  always #2 clock = ~clock;
  rx_port_register_paging u_rx_port_register_paging (.*);
  rx_port_copies_model u_rx_port_copies_model (.*);
  always @(posedge clock) if (rsp_valid) begin
    x = q.size() > 0 ? q.pop_front() : ~rsp_rdata;
    `CHK(rsp_rdata, x)
  end
  task automatic acc(input logic [2:0] s, input logic w, input logic [7:0] a, v);
    logic [7:0] e;
    logic g;
    g = (a > 8'h4d && a < 8'h80) || a[7:4] == 4'hd;
    e = g ? em[{rp[s], a}] : ~a;
    if (a == 8'h4c) e = {s > 1 ? 2'(s - 2) : 2'h0, rp[s], we[s]};
    if (a == 8'h4d) e = {rp[s], fl[rp[s]], 5'h0};
    if (w) e = 8'h0;
    if (a == 8'h4d && !w) fl[rp[s]] = 1'b0;
    if (w && a == 8'h4c) {rp[s], we[s]} = v[5:0];
    if (w && g) for (int p = 0; p < 4; p++) if (we[s][p]) em[{2'(p), a}] = v;
    if (s < 6) q.push_back(e);
    {req_valid, req_source, req_write, req_addr, req_wdata} = {1'b1, s, w, a, v};
    @(posedge clock);
    #1;
  endtask : acc
  task automatic print_verdict;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    #20000 err_total++;
    print_verdict;
  end
  initial begin
    void'($urandom(41));
    for (int i = 0; i < 1024; i++) em[i] = 8'(i ^ (i >> 4));
    repeat (4) @(posedge clock);
    #1 sys_rst = 0;
    for (int s = 0; s < 6; s++) acc(3'(s), 0, 8'h4c, 0);
    $display("test defaults done");
    acc(0, 1, 8'h4c, 8'hea);
    acc(3, 1, 8'h4c, 8'h35);
    for (int s = 0; s < 6; s++) acc(3'(s), 0, 8'h4c, 0);
    for (int i = 0; i < 28; i++) acc(3'(i % 4 == 3 ? 6 : i % 4 * 2 % 3), 1, al[i / 4],
      8'($urandom));
    for (int i = 0; i < 32; i++) acc(0, i % 8 == 0, i % 8 ? al[i % 8 - 1] : 8'h4c,
      8'(i / 8 * 16 + 10));
    $display("test paging done");
    crc_error_event = 4'h6;
    fl = 4'h6;
    acc(7, 0, 0, 0);
    crc_error_event = 4'h0;
    acc(0, 1, 8'h4c, 8'h2a);
    for (int i = 0; i < 3; i++) acc(0, 0, 8'h4d, 0);
    acc(3, 0, 8'h4d, 0);
    acc(0, 1, 8'h4d, 8'hff);
    acc(0, 1, 8'h4c, 8'h1a);
    acc(0, 0, 8'h4d, 0);
    crc_error_event = 4'h2;
    acc(0, 0, 8'h4d, 0);
    fl[1] = 1'b1;
    crc_error_event = 4'h0;
    acc(0, 0, 8'h4d, 0);
    acc(7, 0, 0, 0);
    acc(7, 0, 0, 0);
    `CHK(q.size(), 0)
    $display("test status done");
    print_verdict;
  end
endmodule : tb_rx_port_register_paging
